// *** include/uvx_regs.vh ***
// Constants for the user variable / X register calculation block
// Overview of operation
// - Code 43 writes result into user variable
// - Code 44 writes result into X register
// - Bank byte is variable index, type selects operation
// - Code 43 types 0-4: variable arithmetic with X
// - Code 43 types 5-7: variable AND/OR/XOR X
// - Code 43 type 8: variable gets inverted X
// - Code 43 type 9: variable gets copy of X
// - Type 10 swaps variable and X register
// - Code 43 type 11 compares, changes nothing
// - Code 44 types 0-4: X arithmetic with variable
// - Code 44 types 5-7: X AND/OR/XOR variable
// - Code 44 type 8: X gets inverted variable
// - Code 44 type 9: X gets copy of variable
// - Code 44 type 11 compares, changes nothing
// - Direct mode reply carries status 100, or 3 for an unknown type
// - Reply: host, target, status, instruction, value, checksum
`ifndef UVX_REGS_VH
`define UVX_REGS_VH

// Instruction numbers
`define UVX_INSTR_VX 8'h2B
`define UVX_INSTR_XV 8'h2C

// Operation type codes
`define UVX_OP_ADD 8'h00
`define UVX_OP_SUB 8'h01
`define UVX_OP_MUL 8'h02
`define UVX_OP_DIV 8'h03
`define UVX_OP_MOD 8'h04
`define UVX_OP_AND 8'h05
`define UVX_OP_OR 8'h06
`define UVX_OP_XOR 8'h07
`define UVX_OP_NOT 8'h08
`define UVX_OP_LOAD 8'h09
`define UVX_OP_SWAP 8'h0A
`define UVX_OP_COMP 8'h0B

// Reply status codes
`define UVX_ST_OK 8'h64
`define UVX_ST_BAD_TYPE 8'h03

// Frame layout: byte positions
`define UVX_FRAME_LEN 4'h9
`define UVX_POS_ADDR 4'h0
`define UVX_POS_INSTR 4'h1
`define UVX_POS_TYPE 4'h2
`define UVX_POS_BANK 4'h3
`define UVX_POS_CSUM 4'h8
`define UVX_LAST_POS 4'h8

// Default addresses
`define UVX_HOST_ADDR 8'h02
`define UVX_MODULE_ADDR 8'h01

// Inter-byte gap that abandons a partial frame
`define UVX_CLK_HZ 10000000
`define UVX_GAP_US 1000
`define UVX_GAP_CYC ((`UVX_GAP_US * (`UVX_CLK_HZ / 1000000)))

`endif

// *** design/uvx_alu.v ***
// Operation unit: destination combined with source per type code
`timescale 1ns/1ps
`include "uvx_regs.vh"

module uvx_alu
(
  input wire [7:0] op_in,
  input wire [31:0] dst_in,
  input wire [31:0] src_in,
  output reg [31:0] res_out,
  output reg wr_out,
  output reg swap_out,
  output reg cmp_out,
  output reg bad_out
);

  wire signed [31:0] dst_s;
  wire signed [31:0] src_s;
  wire div_zero;
  wire [31:0] prod;

  assign dst_s = dst_in;
  assign src_s = src_in;
  assign div_zero = (src_in == 32'h00000000);
  assign prod = dst_s * src_s;

  // Result select; division by zero leaves destination unchanged
  always @*
  begin
    res_out = dst_in;
    wr_out = 1'b1;
    swap_out = 1'b0;
    cmp_out = 1'b0;
    bad_out = 1'b0;
    case (op_in)
      `UVX_OP_ADD: res_out = dst_in + src_in;
      `UVX_OP_SUB: res_out = dst_in - src_in;
      `UVX_OP_MUL: res_out = prod;
      `UVX_OP_DIV:
      begin
        if (div_zero)
          wr_out = 1'b0;
        else
          res_out = dst_s / src_s;
      end
      `UVX_OP_MOD:
      begin
        if (div_zero)
          wr_out = 1'b0;
        else
          res_out = dst_s % src_s;
      end
      `UVX_OP_AND: res_out = dst_in & src_in;
      `UVX_OP_OR: res_out = dst_in | src_in;
      `UVX_OP_XOR: res_out = dst_in ^ src_in;
      `UVX_OP_NOT: res_out = ~src_in;
      `UVX_OP_LOAD: res_out = src_in;
      `UVX_OP_SWAP:
      begin
        res_out = src_in;
        swap_out = 1'b1;
      end
      `UVX_OP_COMP:
      begin
        wr_out = 1'b0;
        cmp_out = 1'b1;
      end
      default:
      begin
        wr_out = 1'b0;
        bad_out = 1'b1;
      end
    endcase
  end

endmodule // uvx_alu

// *** design/uvx_frame_rx.v ***
// Command frame receiver with byte-sum check and gap timeout
`timescale 1ns/1ps
`include "uvx_regs.vh"

module uvx_frame_rx
#(
  parameter GAP_CYC = `UVX_GAP_CYC
)
(
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [7:0] byte_in,
  input wire take_in,
  output reg [7:0] addr_out,
  output reg [7:0] instr_out,
  output reg [7:0] type_out,
  output reg [7:0] bank_out,
  output reg done_out,
  output reg sum_ok_out
);

  reg [3:0] pos_ff;
  reg [7:0] sum_ff;
  reg [31:0] gap_ff;

  // Collect bytes in order, accumulate sum over all bytes before the checksum
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pos_ff <= 4'h0;
      sum_ff <= 8'h00;
      gap_ff <= 32'h00000000;
      addr_out <= 8'h00;
      instr_out <= 8'h00;
      type_out <= 8'h00;
      bank_out <= 8'h00;
      done_out <= 1'b0;
      sum_ok_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (take_in)
      begin
        gap_ff <= 32'h00000000;
        case (pos_ff)
          `UVX_POS_ADDR: addr_out <= byte_in;
          `UVX_POS_INSTR: instr_out <= byte_in;
          `UVX_POS_TYPE: type_out <= byte_in;
          `UVX_POS_BANK: bank_out <= byte_in;
          default: ;
        endcase
        if (pos_ff == `UVX_POS_CSUM)
        begin
          pos_ff <= 4'h0;
          sum_ff <= 8'h00;
          done_out <= 1'b1;
          sum_ok_out <= (sum_ff == byte_in);
        end
        else
        begin
          pos_ff <= pos_ff + 4'h1;
          sum_ff <= sum_ff + byte_in;
        end
      end
      else if (pos_ff != 4'h0)
      begin
        // Abandon a stalled partial frame
        if (gap_ff >= GAP_CYC - 1)
        begin
          pos_ff <= 4'h0;
          sum_ff <= 8'h00;
          gap_ff <= 32'h00000000;
        end
        else
          gap_ff <= gap_ff + 32'h00000001;
      end
    end
  end

endmodule // uvx_frame_rx

// *** design/uvx_top.v ***
// Top: user variables, X register, frame decode, execute and reply
`timescale 1ns/1ps
`include "uvx_regs.vh"

module uvx_top
#(
  parameter MODULE_ADDR = `UVX_MODULE_ADDR,
  parameter HOST_ADDR = `UVX_HOST_ADDR,
  parameter GAP_CYC = `UVX_GAP_CYC,
  parameter NUM_VARS = 256
)
(
  input wire clk_sys_in,
  input wire nrst_in,
  input wire [7:0] rx_byte_in,
  input wire rx_valid_in,
  output wire rx_ready_out,
  output wire [7:0] tx_byte_out,
  output wire tx_valid_out,
  input wire tx_ready_in,
  input wire prog_valid_in,
  input wire [7:0] prog_instr_in,
  input wire [7:0] prog_type_in,
  input wire [7:0] prog_var_in,
  output wire prog_ready_out,
  output wire prog_done_out,
  output wire [31:0] x_reg_out,
  output wire cmp_eq_out,
  output wire cmp_gt_out,
  input wire [7:0] var_idx_in,
  output wire [31:0] var_data_out
);

  // One-hot states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_REPLY = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg rx_ready_ff;
  reg prog_ready_ff;
  reg prog_done_ff;
  reg [7:0] tx_byte_ff;
  reg tx_valid_ff;
  reg [3:0] tx_idx_ff;
  reg [31:0] x_ff;
  reg cmp_eq_ff;
  reg cmp_gt_ff;
  reg [31:0] var_data_ff;
  reg [7:0] cmd_instr_ff;
  reg [7:0] cmd_type_ff;
  reg [7:0] cmd_var_ff;
  reg cmd_host_ff;
  reg [7:0] reply_ff [0:8];

  wire rx_take;
  wire [7:0] fr_addr;
  wire [7:0] fr_instr;
  wire [7:0] fr_type;
  wire [7:0] fr_bank;
  wire fr_done;
  wire fr_sum_ok;
  wire fr_accept;
  wire prog_accept;
  wire is_vx;
  wire [31:0] var_rd [0:NUM_VARS-1];
  wire [31:0] cur_var;
  wire [31:0] alu_dst;
  wire [31:0] alu_src;
  wire [31:0] alu_res;
  wire alu_wr;
  wire alu_swap;
  wire alu_cmp;
  wire alu_bad;
  wire var_we;
  wire [31:0] var_wdata;
  wire [7:0] rep_status;
  wire [7:0] rep_csum;
  wire tx_fire;

  assign rx_ready_out = rx_ready_ff;
  assign tx_byte_out = tx_byte_ff;
  assign tx_valid_out = tx_valid_ff;
  assign prog_ready_out = prog_ready_ff;
  assign prog_done_out = prog_done_ff;
  assign x_reg_out = x_ff;
  assign cmp_eq_out = cmp_eq_ff;
  assign cmp_gt_out = cmp_gt_ff;
  assign var_data_out = var_data_ff;

  // Byte taken only while receiver is allowed to run
  assign rx_take = rx_valid_in & rx_ready_ff;

  uvx_frame_rx
  #(
    .GAP_CYC(GAP_CYC)
  )
  u_rx
  (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .byte_in(rx_byte_in),
    .take_in(rx_take),
    .addr_out(fr_addr),
    .instr_out(fr_instr),
    .type_out(fr_type),
    .bank_out(fr_bank),
    .done_out(fr_done),
    .sum_ok_out(fr_sum_ok)
  );

  // Frame acted on only when addressed here, checksum good, known code
  assign fr_accept = fr_done & fr_sum_ok & (fr_addr == MODULE_ADDR[7:0]) &
                     ((fr_instr == `UVX_INSTR_VX) | (fr_instr == `UVX_INSTR_XV));
  // Program request yields to a host byte or frame, so a closing frame is never lost
  assign prog_accept = prog_valid_in & prog_ready_ff & ~fr_accept & ~rx_take &
                       ((prog_instr_in == `UVX_INSTR_VX) | (prog_instr_in == `UVX_INSTR_XV));

  // Operand routing: code 43 writes variable, code 44 writes X
  assign is_vx = (cmd_instr_ff == `UVX_INSTR_VX);
  assign cur_var = var_rd[cmd_var_ff];
  assign alu_dst = is_vx ? cur_var : x_ff;
  assign alu_src = is_vx ? x_ff : cur_var;

  uvx_alu u_alu
  (
    .op_in(cmd_type_ff),
    .dst_in(alu_dst),
    .src_in(alu_src),
    .res_out(alu_res),
    .wr_out(alu_wr),
    .swap_out(alu_swap),
    .cmp_out(alu_cmp),
    .bad_out(alu_bad)
  );

  // Variable written by code 43 results or by a swap
  assign var_we = state_ff[1] & alu_wr & (is_vx | alu_swap);
  assign var_wdata = is_vx ? alu_res : x_ff;

  // User variable storage, one entry per index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VARS; gi = gi + 1)
    begin : g_var
      reg [31:0] val_ff;
      always @(posedge clk_sys_in or negedge nrst_in)
      begin
        if (!nrst_in)
          val_ff <= 32'h00000000;
        else if (var_we && (cmd_var_ff == gi))
          val_ff <= var_wdata;
      end
      assign var_rd[gi] = val_ff;
    end
  endgenerate

  // Reply fields; value bytes always zero
  assign rep_status = alu_bad ? `UVX_ST_BAD_TYPE : `UVX_ST_OK;
  assign rep_csum = HOST_ADDR[7:0] + MODULE_ADDR[7:0] + rep_status + cmd_instr_ff;
  assign tx_fire = tx_valid_ff & tx_ready_in;

  // State sequencing
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (fr_accept || prog_accept)
          nxt_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (cmd_host_ff)
          nxt_state = ST_REPLY;
        else
          nxt_state = ST_IDLE;
      end
      ST_REPLY:
      begin
        if (tx_fire && (tx_idx_ff == `UVX_LAST_POS))
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Control, command latch and handshake flags
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_ff <= ST_IDLE;
      rx_ready_ff <= 1'b0;
      prog_ready_ff <= 1'b0;
      prog_done_ff <= 1'b0;
      cmd_instr_ff <= 8'h00;
      cmd_type_ff <= 8'h00;
      cmd_var_ff <= 8'h00;
      cmd_host_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rx_ready_ff <= (nxt_state == ST_IDLE);
      prog_ready_ff <= (nxt_state == ST_IDLE);
      prog_done_ff <= state_ff[1] & ~cmd_host_ff;
      if (state_ff[0] && fr_accept)
      begin
        cmd_instr_ff <= fr_instr;
        cmd_type_ff <= fr_type;
        cmd_var_ff <= fr_bank;
        cmd_host_ff <= 1'b1;
      end
      else if (state_ff[0] && prog_accept)
      begin
        cmd_instr_ff <= prog_instr_in;
        cmd_type_ff <= prog_type_in;
        cmd_var_ff <= prog_var_in;
        cmd_host_ff <= 1'b0;
      end
    end
  end

  // X register update and compare flags
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      x_ff <= 32'h00000000;
      cmp_eq_ff <= 1'b0;
      cmp_gt_ff <= 1'b0;
    end
    else if (state_ff[1])
    begin
      if (alu_wr && (!is_vx || alu_swap))
        x_ff <= is_vx ? cur_var : alu_res;
      if (alu_cmp)
      begin
        cmp_eq_ff <= (alu_dst == alu_src);
        cmp_gt_ff <= ($signed(alu_dst) > $signed(alu_src));
      end
    end
  end

  // Debug read port for a variable
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      var_data_ff <= 32'h00000000;
    else
      var_data_ff <= var_rd[var_idx_in];
  end

  // Reply build in execute cycle, then byte-wise send
  always @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tx_byte_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_idx_ff <= 4'h0;
      reply_ff[0] <= 8'h00;
      reply_ff[1] <= 8'h00;
      reply_ff[2] <= 8'h00;
      reply_ff[3] <= 8'h00;
      reply_ff[4] <= 8'h00;
      reply_ff[5] <= 8'h00;
      reply_ff[6] <= 8'h00;
      reply_ff[7] <= 8'h00;
      reply_ff[8] <= 8'h00;
    end
    else if (state_ff[1] && cmd_host_ff)
    begin
      reply_ff[1] <= MODULE_ADDR[7:0];
      reply_ff[2] <= rep_status;
      reply_ff[3] <= cmd_instr_ff;
      reply_ff[8] <= rep_csum;
      tx_byte_ff <= HOST_ADDR[7:0];
      tx_valid_ff <= 1'b1;
      tx_idx_ff <= 4'h0;
    end
    else if (tx_fire)
    begin
      if (tx_idx_ff == `UVX_LAST_POS)
      begin
        tx_valid_ff <= 1'b0;
        tx_idx_ff <= 4'h0;
      end
      else
      begin
        tx_idx_ff <= tx_idx_ff + 4'h1;
        tx_byte_ff <= reply_ff[tx_idx_ff + 4'h1];
      end
    end
  end

endmodule // uvx_top

// *** verif/uvx_top_asserts.sv ***
// Port-level assertions for the calculation block
`timescale 1ns/1ps
module uvx_top_asserts
#(
  parameter HOST_ADDR = 8'h02
)
(
  input wire clk_sys_in,
  input wire nrst_in,
  input wire rx_ready_out,
  input wire [7:0] tx_byte_out,
  input wire tx_valid_out,
  input wire tx_ready_in,
  input wire prog_valid_in,
  input wire [7:0] prog_instr_in,
  input wire [7:0] prog_type_in,
  input wire prog_done_out,
  input wire [31:0] x_reg_out,
  input wire [31:0] var_data_out
);
  // All checks run on the system clock and rest during reset
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // Program completions split by instruction
  wire dn_vx = prog_done_out && prog_instr_in == 8'h2B;
  wire dn_xv = prog_done_out && prog_instr_in == 8'h2C;
  a_done_one_cycle: assert property (prog_done_out |=> !prog_done_out)
    else $error("program done pulse too long");
  a_done_has_cause: assert property (prog_done_out |-> $past(prog_valid_in, 2))
    else $error("program done without request");
  a_reply_holds: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
    else $error("reply byte dropped while stalled");
  a_reply_starts: assert property ($rose(tx_valid_out) |-> tx_byte_out == HOST_ADDR)
    else $error("reply does not open with host address");
  a_rx_shut_reply: assert property (tx_valid_out |-> !rx_ready_out)
    else $error("command link open during reply");
  a_cmp_keeps_x: assert property (prog_done_out && prog_type_in == 8'h0B |-> $stable(x_reg_out))
    else $error("compare changed X");
  a_vx_keeps_x: assert property (dn_vx && prog_type_in != 8'h0A |-> $stable(x_reg_out))
    else $error("variable update changed X");
  a_x_gets_copy: assert property (dn_xv && prog_type_in == 8'h09 |-> x_reg_out == var_data_out)
    else $error("X load mismatch");
  a_x_gets_invert: assert property (dn_xv && prog_type_in == 8'h08 |-> x_reg_out == ~var_data_out)
    else $error("X invert mismatch");
  a_var_gets_copy: assert property (dn_vx && prog_type_in == 8'h09 |=> var_data_out == x_reg_out)
    else $error("variable load mismatch");
endmodule // uvx_top_asserts

bind uvx_top uvx_top_asserts #(.HOST_ADDR(HOST_ADDR)) i_uvx_top_asserts (
  .clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in),
  .rx_ready_out(rx_ready_out),
  .tx_byte_out(tx_byte_out),
  .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in),
  .prog_valid_in(prog_valid_in),
  .prog_instr_in(prog_instr_in),
  .prog_type_in(prog_type_in),
  .prog_done_out(prog_done_out),
  .x_reg_out(x_reg_out),
  .var_data_out(var_data_out)
);

// *** verif/uvx_host_model.sv ***
// Host model: sends command frames and collects replies
`timescale 1ns/1ps
module uvx_host_model
(
  input wire clk_sys_in,
  input wire rx_ready_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire [7:0] tx_byte_in,
  input wire tx_valid_in,
  output logic tx_ready_out,
  input wire stall_in
);
  logic [7:0] rep [0:8];
  int rep_cnt;
  initial
  begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
    rep_cnt = 0;
  end
  // Reply sink, optionally refusing every other cycle
  always @(posedge clk_sys_in)
  begin
    if (tx_valid_in && tx_ready_out && rep_cnt < 9)
    begin
      rep[rep_cnt] <= tx_byte_in;
      rep_cnt <= rep_cnt + 1;
    end
    tx_ready_out <= #1 stall_in ? ~tx_ready_out : 1'b1;
  end
  // One frame, each byte held until the device takes it
  task automatic send(input logic [7:0] a, ins, t, v, bad);
    logic [7:0] f [0:8];
    f = '{a, ins, t, v, 8'h5A, 8'hC3, 8'h01, 8'hFE, 8'h00};
    for (int i = 0; i < 8; i++)
      f[8] = f[8] + f[i];
    f[8] = f[8] + bad;
    @(posedge clk_sys_in);
    for (int i = 0; i < 9; i++)
    begin
      #1;
      rx_valid_out = 1'b1;
      rx_byte_out = f[i];
      do @(negedge clk_sys_in); while (!rx_ready_in);
      @(posedge clk_sys_in);
    end
    #1;
    rx_valid_out = 1'b0;
    rx_byte_out = ~f[8];
  endtask
endmodule // uvx_host_model

// *** verif/user_var_x_register_alu_tb.sv ***
// Testbench for the calculation block
`timescale 1ns/1ps
module user_var_x_register_alu_tb;
  logic clk_sys_in, nrst_in, prog_valid_in, stall;
  logic [7:0] prog_instr_in, prog_type_in, prog_var_in, var_idx_in, tx_byte_out, rx_byte_in;
  logic [31:0] x_reg_out, var_data_out, xm;
  logic [31:0] vm [0:255];
  wire rx_ready_out, tx_valid_out, tx_ready_in, rx_valid_in, prog_ready_out, prog_done_out, cmp_eq_out, cmp_gt_out;
  int err_total, num_checks;
  uvx_top #(.GAP_CYC(20)) i_uvx_top (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .rx_byte_in(rx_byte_in),
    .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in), .prog_valid_in(prog_valid_in),
    .prog_instr_in(prog_instr_in), .prog_type_in(prog_type_in), .prog_var_in(prog_var_in),
    .prog_ready_out(prog_ready_out), .prog_done_out(prog_done_out), .x_reg_out(x_reg_out),
    .cmp_eq_out(cmp_eq_out), .cmp_gt_out(cmp_gt_out), .var_idx_in(var_idx_in), .var_data_out(var_data_out));
  uvx_host_model i_host (.clk_sys_in(clk_sys_in), .rx_ready_in(rx_ready_out), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in), .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in), .stall_in(stall));
  // Clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reference operation, destination unchanged where undefined
  function automatic logic [31:0] calc(input logic [7:0] t, input logic [31:0] d, s);
    case (t)
      8'h00: return d + s;
      8'h01: return d - s;
      8'h02: return d * s;
      8'h03: if (s == 0) return d; else return $signed(d) / $signed(s);
      8'h04: if (s == 0) return d; else return $signed(d) % $signed(s);
      8'h05: return d & s;
      8'h06: return d | s;
      8'h07: return d ^ s;
      8'h08: return ~s;
      8'h09: return s;
      default: return d;
    endcase
  endfunction
  // Update the reference copies after one operation
  task automatic apply(input logic [7:0] ins, t, v);
    logic [31:0] tmp;
    tmp = xm;
    if (t == 8'h0A)
    begin
      xm = vm[v];
      vm[v] = tmp;
    end
    else if (ins == 8'h2B)
      vm[v] = calc(t, vm[v], xm);
    else
      xm = calc(t, xm, vm[v]);
  endtask
  task automatic chk_state(input logic [7:0] v);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk("x register", x_reg_out, xm);
    chk("user variable", var_data_out, vm[v]);
  endtask
  // One stored-program operation
  task automatic step(input logic [7:0] ins, t, v);
    logic [31:0] d, s;
    int n;
    @(posedge clk_sys_in);
    #1;
    chk("program ready", {31'h0, prog_ready_out}, 32'h1);
    prog_valid_in = 1'b1;
    prog_instr_in = ins;
    prog_type_in = t;
    prog_var_in = v;
    var_idx_in = v;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    while (prog_done_out !== 1'b1 && n < 20);
    chk("program done", {31'h0, prog_done_out}, 32'h1);
    prog_valid_in = 1'b0;
    d = (ins == 8'h2B) ? vm[v] : xm;
    s = (ins == 8'h2B) ? xm : vm[v];
    apply(ins, t, v);
    chk_state(v);
    if (t == 8'h0B)
    begin
      chk("equal flag", {31'h0, cmp_eq_out}, {31'h0, d == s});
      chk("greater flag", {31'h0, cmp_gt_out}, {31'h0, $signed(d) > $signed(s)});
    end
  endtask
  // One command frame; st of zero means no reply is due
  task automatic frame(input logic [7:0] a, ins, t, v, bad, st);
    logic [7:0] e [0:8];
    int n;
    i_host.rep_cnt = 0;
    var_idx_in = v;
    i_host.send(a, ins, t, v, bad);
    for (n = 0; n < 80 && i_host.rep_cnt < 9; n++)
      @(posedge clk_sys_in);
    e = '{8'h02, 8'h01, st, ins, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++)
      e[8] = e[8] + e[k];
    chk("reply count", i_host.rep_cnt, (st == 0) ? 0 : 9);
    for (int k = 0; k < 9 && st != 0; k++)
      chk("reply byte", {24'h0, i_host.rep[k]}, {24'h0, e[k]});
    if (st != 0)
      apply(ins, t, v);
    chk_state(v);
  endtask
  task automatic t_seed;
    step(8'h2C, 8'h08, 8'h00);
    step(8'h2B, 8'h01, 8'h07);
    step(8'h2C, 8'h01, 8'h07);
    step(8'h2B, 8'h01, 8'h07);
    step(8'h2C, 8'h02, 8'h07);
    step(8'h2B, 8'h09, 8'hFF);
    step(8'h2B, 8'h0B, 8'hFF);
    step(8'h2B, 8'h08, 8'hFF);
    $display("t_seed done");
  endtask
  task automatic t_types;
    for (int t = 0; t < 13; t++)
    begin
      step(8'h2B, t[7:0], 8'h07);
      step(8'h2C, t[7:0], 8'h07);
    end
    $display("t_types done");
  endtask
  task automatic t_frames;
    stall = 1'b1;
    frame(8'h01, 8'h2B, 8'h01, 8'h1B, 8'h00, 8'h64);
    stall = 1'b0;
    frame(8'h01, 8'h2C, 8'h0A, 8'h1B, 8'h00, 8'h64);
    $display("t_frames done");
  endtask
  task automatic t_refuse;
    frame(8'h01, 8'h2C, 8'h0C, 8'h1B, 8'h00, 8'h03);
    frame(8'h01, 8'h2B, 8'h00, 8'h1B, 8'h01, 8'h00);
    frame(8'h03, 8'h2B, 8'h00, 8'h1B, 8'h00, 8'h00);
    $display("t_refuse done");
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #1000000;
    err_total++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    err_total = 0;
    num_checks = 0;
    xm = 32'h0;
    foreach (vm[i])
      vm[i] = 32'h0;
    {nrst_in, prog_valid_in, stall} = 3'b000;
    {prog_instr_in, prog_type_in, prog_var_in, var_idx_in} = 32'h0;
    repeat (16) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    t_seed();
    t_types();
    t_frames();
    t_refuse();
    end_sim();
  end
endmodule // user_var_x_register_alu_tb
